// file: hw/hvwps_guard.sv
/*
  Guard logic for the high-voltage wake pin and its shared fail/general-purpose
  pin while the voltage sense path is active, plus the pin qualification filters.
  Assumes command strobes are one-cycle pulses synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Sense enabled: pulls off and internal wake signal blocked.
// - Sense enabled: pull config stored but applied only after sense disabled.
// - Sense enabled: writes changing pin function are rejected, contents kept.
// - Sense enable refused while fail output configured; command error set.
// - Sense enabled: wake event and wake level status not updated.
// - Sleep request with pin wake only and sense on: error, enter restart.
// - Wake input level change accepted only after stable filter time.
// - Wake events ignored during blanking time after wake input enabled.
// - Switch overcurrent qualified by filter time before shutdown.
// - High-side open load qualified by filter time before reporting.
// - Sense enabled: fail output, general purpose and test attempts flag error.
// - Overcurrent shutdown sets flag and forces function to off.
// - Qualified open load sets flag without shutting the switch down.
module hvwps_guard (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // Commands and pin sensing
  input  wire hvwps_pkg::hvwps_cmd_t   cmd,
  input  wire hvwps_pkg::hvwps_sense_t sense,
  input  wire logic                 cmd_err_clr,
  input  wire logic                 status_clr,
  // Configuration and status
  output logic [2:0]                pin_function,
  output logic [1:0]                wake_pull_config,
  output logic                      hv_sense_enable,
  output logic                      cmd_error_flag,
  output logic                      wake_event_status,
  output logic                      wake_level_status,
  output logic                      pin_overcurrent_flag,
  output logic                      pin_openload_flag,
  // Pin control
  output logic                      pull_up_en,
  output logic                      pull_down_en,
  output logic                      hv_wake_input,
  output logic                      switch_on,
  output logic                      fail_output_drive,
  output hvwps_pkg::hvwps_mode_t    mode
);

  hvwps_pkg::hvwps_state_t s_q;
  hvwps_pkg::hvwps_state_t s_d;

  function automatic logic is_switch(input logic [2:0] f);
    is_switch = (f == hvwps_pkg::FUNC_LS) || (f == hvwps_pkg::FUNC_HS)
             || (f == hvwps_pkg::FUNC_HS_CSENSE);
  endfunction

  function automatic logic is_high_side(input logic [2:0] f);
    is_high_side = (f == hvwps_pkg::FUNC_HS);
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic wk_ok;
    logic set_err;
    logic oc_shut;
    logic ol_set;
    wk_ok = 1'b0;
    ol_set = 1'b0;
    set_err = 1'b0;
    oc_shut = 1'b0;
    s_d = s_q;

    // Sense enable, refused while the fail output function is selected.
    if (cmd.sense_wr)
    begin
      if (cmd.sense_data && (s_q.func_q == hvwps_pkg::FUNC_FAIL_OUT))
        set_err = 1'b1;
      else
        s_d.sense_en_q = cmd.sense_data;
    end

    // Pull config always stored; its effect is gated on the outputs.
    if (cmd.pull_wr)
      s_d.pull_q = cmd.pull_data;

    // Blanking counts down first, so a wake input write in this cycle reloads it.
    if (s_q.blank_cnt_q != '0)
      s_d.blank_cnt_q = s_q.blank_cnt_q - 1'b1;

    // Function writes that change the value are blocked while sensing.
    if (cmd.func_wr)
    begin
      if (s_q.sense_en_q)
      begin
        if (cmd.func_data != s_q.func_q)
          set_err = 1'b1;
      end
      else
      begin
        s_d.func_q = cmd.func_data;
        if (cmd.func_data == hvwps_pkg::FUNC_WAKE_IN)
          s_d.blank_cnt_q = hvwps_pkg::CNT_W'(hvwps_pkg::WK_BLANK_CYC);
      end
    end
    if (cmd.fo_test_wr && s_q.sense_en_q)
      set_err = 1'b1;

    // Sleep request handling.
    if (cmd.sleep_req)
    begin
      if (s_q.sense_en_q && cmd.pin_wake_en && !cmd.other_wake_en)
      begin
        set_err = 1'b1;
        s_d.mode_q = hvwps_pkg::MODE_RESTART;
      end
      else
        s_d.mode_q = hvwps_pkg::MODE_SLEEP;
    end

    // Wake input filter.
    if ((s_q.func_q == hvwps_pkg::FUNC_WAKE_IN) && !s_q.sense_en_q)
    begin
      if (sense.pin_level == s_q.wk_filt_q)
        s_d.wk_cnt_q = '0;
      else if (s_q.wk_cnt_q == hvwps_pkg::CNT_W'(hvwps_pkg::WK_FILT_CYC - 1))
      begin
        s_d.wk_cnt_q = '0;
        s_d.wk_filt_q = sense.pin_level;
        wk_ok = 1'b1;
      end
      else
        s_d.wk_cnt_q = s_q.wk_cnt_q + 1'b1;
    end
    else
      s_d.wk_cnt_q = '0;
    if (!s_q.sense_en_q)
      s_d.wake_level_q = s_q.wk_filt_q;
    if (wk_ok && (s_q.blank_cnt_q == '0))
      s_d.wake_event_q = 1'b1;

    // Overcurrent filter and shutdown.
    // The sense path keeps the switch off, so no fault is counted then.
    if (is_switch(s_q.func_q) && !s_q.sense_en_q && sense.overcurrent)
    begin
      if (s_q.oc_cnt_q == hvwps_pkg::CNT_W'(hvwps_pkg::OC_FILT_CYC - 1))
        oc_shut = 1'b1;
      else
        s_d.oc_cnt_q = s_q.oc_cnt_q + 1'b1;
    end
    else
      s_d.oc_cnt_q = '0;
    if (oc_shut)
    begin
      s_d.oc_cnt_q = '0;
      s_d.oc_flag_q = 1'b1;
      s_d.func_q = hvwps_pkg::FUNC_OFF;
    end

    // Open load filter; flag only, switch stays on.
    if (is_high_side(s_q.func_q) && !s_q.sense_en_q && sense.openload && !s_q.ol_flag_q)
    begin
      if (s_q.ol_cnt_q == hvwps_pkg::CNT_W'(hvwps_pkg::OL_FILT_CYC - 1))
      begin
        s_d.ol_cnt_q = '0;
        ol_set = 1'b1;
        s_d.ol_flag_q = 1'b1;
      end
      else
        s_d.ol_cnt_q = s_q.ol_cnt_q + 1'b1;
    end
    else
      s_d.ol_cnt_q = '0;

    // Software clears lose against a same-cycle set.
    if (status_clr)
    begin
      s_d.wake_event_q = wk_ok && (s_q.blank_cnt_q == '0) && !s_q.sense_en_q;
      s_d.oc_flag_q = oc_shut;
      s_d.ol_flag_q = ol_set;
    end
    if (cmd_err_clr)
      s_d.cmd_err_q = 1'b0;
    if (set_err)
      s_d.cmd_err_q = 1'b1;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.func_q <= hvwps_pkg::RST_FUNC;
      s_q.pull_q <= hvwps_pkg::RST_PULL;
      s_q.mode_q <= hvwps_pkg::MODE_NORMAL;
    end
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign pin_function = s_q.func_q;
  assign wake_pull_config = s_q.pull_q;
  assign hv_sense_enable = s_q.sense_en_q;
  assign cmd_error_flag = s_q.cmd_err_q;
  assign wake_event_status = s_q.wake_event_q;
  assign wake_level_status = s_q.wake_level_q;
  assign pin_overcurrent_flag = s_q.oc_flag_q;
  assign pin_openload_flag = s_q.ol_flag_q;
  assign pull_up_en = !s_q.sense_en_q && s_q.pull_q[0];
  assign pull_down_en = !s_q.sense_en_q && s_q.pull_q[1];
  assign hv_wake_input = !s_q.sense_en_q && s_q.wk_filt_q;
  assign switch_on = is_switch(s_q.func_q) && !s_q.sense_en_q;
  assign fail_output_drive = (s_q.func_q == hvwps_pkg::FUNC_FAIL_OUT) && !s_q.sense_en_q;
  assign mode = s_q.mode_q;

endmodule

`default_nettype wire

// file: hw/hvwps_pkg.sv
/*
  Constants and carrier types for the high-voltage wake pin sense guard.
  Assumes a 100 MHz clock and that all inputs are synchronous to it.
*/
`default_nettype none

package hvwps_pkg;

  // ------------------------------------------------------------------
  // Pin function encodings
  // ------------------------------------------------------------------
  typedef logic [2:0] hvwps_func_t;
  localparam hvwps_func_t FUNC_FAIL_OUT = 3'h0;
  localparam hvwps_func_t FUNC_HS_CSENSE = 3'h3;
  localparam hvwps_func_t FUNC_OFF = 3'h4;
  localparam hvwps_func_t FUNC_WAKE_IN = 3'h5;
  localparam hvwps_func_t FUNC_LS = 3'h6;
  localparam hvwps_func_t FUNC_HS = 3'h7;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam hvwps_func_t RST_FUNC = FUNC_FAIL_OUT;
  localparam logic [1:0] RST_PULL = 2'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int T_WK_FILT_MIN_US = 13;
  localparam int T_WK_BLANK_MIN_US = 24;
  localparam int T_OC_FILT_MIN_US = 20;
  localparam int T_OL_FILT_MIN_US = 51;
  localparam int WK_FILT_CYC = T_WK_FILT_MIN_US * CLK_MHZ;
  localparam int WK_BLANK_CYC = T_WK_BLANK_MIN_US * CLK_MHZ;
  localparam int OC_FILT_CYC = T_OC_FILT_MIN_US * CLK_MHZ;
  localparam int OL_FILT_CYC = T_OL_FILT_MIN_US * CLK_MHZ;
  localparam int CNT_W = 13;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLEEP,
    MODE_RESTART
  } hvwps_mode_t;

  typedef struct packed {
    logic        func_wr;
    hvwps_func_t func_data;
    logic        pull_wr;
    logic [1:0]  pull_data;
    logic        sense_wr;
    logic        sense_data;
    logic        fo_test_wr;
    logic        sleep_req;
    logic        other_wake_en;
    logic        pin_wake_en;
  } hvwps_cmd_t;

  typedef struct packed {
    logic        pin_level;
    logic        overcurrent;
    logic        openload;
  } hvwps_sense_t;

  typedef struct packed {
    hvwps_func_t func_q;
    logic [1:0]  pull_q;
    logic        sense_en_q;
    logic        cmd_err_q;
    logic        wk_filt_q;
    logic [CNT_W-1:0] wk_cnt_q;
    logic [CNT_W-1:0] blank_cnt_q;
    logic [CNT_W-1:0] oc_cnt_q;
    logic [CNT_W-1:0] ol_cnt_q;
    logic        wake_event_q;
    logic        wake_level_q;
    logic        oc_flag_q;
    logic        ol_flag_q;
    hvwps_mode_t mode_q;
  } hvwps_state_t;

endpackage

`default_nettype wire

// file: tb/hvwps_checker.sv
/* Assertions on the ports of the wake pin sense guard.
   Bound into hvwps_guard; watches its ports only. */
`timescale 1ns/1ns
`default_nettype none
module hvwps_checker (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   nrst,
  // Inputs
  input wire hvwps_pkg::hvwps_cmd_t   cmd,
  input wire hvwps_pkg::hvwps_sense_t sense,
  // Outputs
  input wire logic [2:0]             pin_function,
  input wire logic                   hv_sense_enable,
  input wire logic                   cmd_error_flag,
  input wire logic                   wake_level_status,
  input wire logic                   pin_overcurrent_flag,
  input wire logic                   pin_openload_flag,
  input wire logic                   pull_up_en,
  input wire logic                   pull_down_en,
  input wire logic                   hv_wake_input,
  input wire logic                   switch_on,
  input wire hvwps_pkg::hvwps_mode_t mode
);
  localparam int OC_MIN = 1997;
  localparam int OL_MIN = 5097;
  int oc_q;
  int ol_q;
  // Counts cycles of a fault seen while the switch is on.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      oc_q <= 0;
      ol_q <= 0;
    end
    else
    begin
      oc_q <= (switch_on && sense.overcurrent) ? oc_q + 1 : 0;
      ol_q <= (switch_on && sense.openload) ? ol_q + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_err;
    cmd_error_flag;
  endsequence
  property p_gate;
    hv_sense_enable |-> !pull_up_en && !pull_down_en && !hv_wake_input;
  endproperty
  a_gate: assert property (p_gate) else $error("pins active while sensing");
  property p_fo_refuse;
    cmd.sense_wr && cmd.sense_data && pin_function == hvwps_pkg::FUNC_FAIL_OUT
      |=> !hv_sense_enable ##0 s_err;
  endproperty
  a_fo_refuse: assert property (p_fo_refuse) else $error("sense set over fail output");
  property p_func_lock;
    hv_sense_enable && cmd.func_wr && cmd.func_data != pin_function
      |=> pin_function == $past(pin_function) ##0 s_err;
  endproperty
  a_func_lock: assert property (p_func_lock) else $error("function changed while sensing");
  property p_lvl_hold;
    hv_sense_enable |=> $stable(wake_level_status);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("level status moved");
  property p_sleep;
    cmd.sleep_req && hv_sense_enable && cmd.pin_wake_en && !cmd.other_wake_en
      |=> mode == hvwps_pkg::MODE_RESTART ##0 s_err;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not refused");
  property p_fo_test;
    hv_sense_enable && cmd.fo_test_wr |=> s_err;
  endproperty
  a_fo_test: assert property (p_fo_test) else $error("test attempt not flagged");
  property p_oc_off;
    $rose(pin_overcurrent_flag) |-> pin_function == hvwps_pkg::FUNC_OFF && !switch_on;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("switch not shut down");
  property p_oc_filt;
    $rose(pin_overcurrent_flag) |-> oc_q >= OC_MIN;
  endproperty
  a_oc_filt: assert property (p_oc_filt) else $error("overcurrent too early");
  property p_ol;
    $rose(pin_openload_flag) |-> ol_q >= OL_MIN && switch_on;
  endproperty
  a_ol: assert property (p_ol) else $error("open load wrong");
endmodule
bind hvwps_guard hvwps_checker i_hvwps_checker (.mclk, .nrst, .cmd, .sense, .pin_function,
  .hv_sense_enable, .cmd_error_flag, .wake_level_status, .pin_overcurrent_flag,
  .pin_openload_flag, .pull_up_en, .pull_down_en, .hv_wake_input, .switch_on, .mode);
`default_nettype wire

// file: tb/tb_top.sv
/* Self-checking bench for the wake pin sense guard.
   Drives the ports directly; the checker is bound in. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
`define WAITHI(s) for (k = 0; k < 400 && (s) !== 1'h1; k++) cyc(1); \
  if (k == 400) begin miscompares++; final_report(); end
module tb_top;
  logic mclk, nrst, cmd_err_clr, status_clr, hv_sense_enable, cmd_error_flag;
  logic wake_event_status, wake_level_status, pin_overcurrent_flag, pin_openload_flag;
  logic pull_up_en, pull_down_en, hv_wake_input, switch_on, fail_output_drive;
  logic [2:0] pin_function;
  logic [1:0] wake_pull_config;
  hvwps_pkg::hvwps_cmd_t cmd;
  hvwps_pkg::hvwps_sense_t sense;
  hvwps_pkg::hvwps_mode_t mode;
  int k;
  int miscompares = 0;
  int num_checks = 0;
  hvwps_guard i_hvwps_guard (.mclk, .nrst, .cmd, .sense, .cmd_err_clr, .status_clr,
    .pin_function, .wake_pull_config, .hv_sense_enable, .cmd_error_flag, .wake_event_status,
    .wake_level_status, .pin_overcurrent_flag, .pin_openload_flag, .pull_up_en,
    .pull_down_en, .hv_wake_input, .switch_on, .fail_output_drive, .mode);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Kinds: 0 function, 1 pull, 2 sense, 3 output test, 4 sleep with pin wake only,
  // 5 sleep with pin wake and another wake source.
  task automatic op(input int t, input logic [2:0] v);
    hvwps_pkg::hvwps_cmd_t c;
    c = '0;
    case (t)
      0: {c.func_wr, c.func_data} = {1'h1, v};
      1: {c.pull_wr, c.pull_data} = {1'h1, v[1:0]};
      2: {c.sense_wr, c.sense_data} = {1'h1, v[0]};
      3: c.fo_test_wr = 1'h1;
      5: {c.sleep_req, c.pin_wake_en, c.other_wake_en} = 3'h7;
      default: {c.sleep_req, c.pin_wake_en} = 2'h3;
    endcase
    cmd = c;
    cyc(1);
    cmd = '0;
  endtask
  task automatic clr;
    {cmd_err_clr, status_clr} = 2'h3;
    cyc(1);
    {cmd_err_clr, status_clr} = 2'h0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    {nrst, cmd_err_clr, status_clr} = 3'h0;
    cmd = '0;
    sense = '0;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'h1;
    `CHK("fo_drive", 1'h1, fail_output_drive)
    op(2, 3'h1);
    `CHK("sense", 1'h0, hv_sense_enable)
    `CHK("err", 1'h1, cmd_error_flag)
    clr();
    op(0, hvwps_pkg::FUNC_OFF);
    op(1, 3'h1);
    `CHK("pu", 1'h1, pull_up_en)
    op(2, 3'h1);
    `CHK("pu", 1'h0, pull_up_en)
    op(1, 3'h2);
    `CHK("pull", 2'h2, wake_pull_config)
    `CHK("pd", 1'h0, pull_down_en)
    op(0, hvwps_pkg::FUNC_LS);
    `CHK("func", hvwps_pkg::FUNC_OFF, pin_function)
    `CHK("err", 1'h1, cmd_error_flag)
    clr();
    op(0, hvwps_pkg::FUNC_OFF);
    `CHK("err", 1'h0, cmd_error_flag)
    op(2, 3'h0);
    `CHK("pd", 1'h1, pull_down_en)
    op(0, hvwps_pkg::FUNC_LS);
    sense.overcurrent = 1'h1;
    cyc(1900);
    `CHK("oc", 1'h0, pin_overcurrent_flag)
    `WAITHI(pin_overcurrent_flag)
    `CHK("func", hvwps_pkg::FUNC_OFF, pin_function)
    `CHK("sw", 1'h0, switch_on)
    sense.overcurrent = 1'h0;
    clr();
    op(0, hvwps_pkg::FUNC_HS);
    sense.openload = 1'h1;
    cyc(5000);
    `CHK("ol", 1'h0, pin_openload_flag)
    `WAITHI(pin_openload_flag)
    `CHK("sw", 1'h1, switch_on)
    sense.openload = 1'h0;
    op(0, hvwps_pkg::FUNC_WAKE_IN);
    cyc(2500);
    sense.pin_level = 1'h1;
    cyc(1200);
    `CHK("wk", 1'h0, hv_wake_input)
    `WAITHI(hv_wake_input)
    cyc(2);
    `CHK("ev", 1'h1, wake_event_status)
    sense.pin_level = 1'h0;
    cyc(1500);
    clr();
    op(0, hvwps_pkg::FUNC_OFF);
    op(0, hvwps_pkg::FUNC_WAKE_IN);
    sense.pin_level = 1'h1;
    cyc(2000);
    `CHK("ev", 1'h0, wake_event_status)
    op(2, 3'h1);
    sense.pin_level = 1'h0;
    cyc(1500);
    `CHK("lvl", 1'h1, wake_level_status)
    `CHK("ev", 1'h0, wake_event_status)
    op(3, 3'h0);
    `CHK("err", 1'h1, cmd_error_flag)
    clr();
    op(4, 3'h0);
    `CHK("mode", hvwps_pkg::MODE_RESTART, mode)
    `CHK("err", 1'h1, cmd_error_flag)
    clr();
    op(5, 3'h0);
    `CHK("mode", hvwps_pkg::MODE_SLEEP, mode)
    `CHK("err", 1'h0, cmd_error_flag)
    final_report();
  end
endmodule
`default_nettype wire
